/* File: hw/pel_params.svh */
// Purpose: Constants for the PWM enable, fault and lock block.
// Assumes: Byte-wide registers on a plain register port.
// Notes:   Offsets are byte addresses of the register port.
`ifndef PEL_PARAMS_SVH
`define PEL_PARAMS_SVH
`define PEL_OFS_OVR        8'hb7
`define PEL_OFS_EN         8'hcf
`define PEL_OFS_CTRL       8'hd2
`define PEL_OFS_PERL       8'hd3
`define PEL_OFS_PERH       8'hd4
`define PEL_OFS_DUTL       8'hd5
`define PEL_OFS_DUTH       8'hd6
`define PEL_OFS_DEAD       8'hd7
`define PEL_OFS_LOCK       8'he7
`define PEL_OFS_IRQ_STAT   8'he8
`define PEL_OFS_IRQ_MASK   8'he9
`define PEL_UNLOCK_KEY     8'h55
`define PEL_EN_MASK        8'h49
`define PEL_BIT_FAULT_EN   6
`define PEL_BIT_COMP_EN    3
`define PEL_BIT_PRIM_EN    0
`define PEL_BIT_OVR        0
`define PEL_BIT_IE         7
`define PEL_BIT_IF         6
`define PEL_BIT_FAULT_STAT 4
`define PEL_BIT_FAULT_LVL  3
`define PEL_BIT_POL        2
`define PEL_CTRL_WMASK     8'h8f
`define PEL_CTRL_RMASK     8'hdf
`define PEL_IRQ_PERIOD     0
`define PEL_IRQ_FAULT      1
`define PEL_IRQ_MASK_W     8'h03
`define PEL_CNT_ZERO       12'h000
`define PEL_CNT_ONE        12'h001
`define PEL_DEAD_ZERO      8'h00
`define PEL_DEAD_ONE       8'h01
`define PEL_BYTE_ZERO      8'h00
`endif

/* File: hw/pel_pkg.sv */
// Purpose: Types shared by the PWM enable, fault and lock block.
// Assumes: Included constants header sets field positions.
// Notes:   Holds types only.
`default_nettype none
package pel_pkg;
   typedef logic [11:0] pel_cnt_t;
   // Register port request from software.
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pel_bus_s;
   // Pin drive towards the two output pads.
   typedef struct packed
   {
      logic prim_o;
      logic prim_oe;
      logic comp_o;
      logic comp_oe;
   } pel_pins_s;
endpackage
`default_nettype wire

/* File: hw/pel_sync.sv */
// Purpose: Two-flop synchroniser for the fault pin.
// Assumes: Input is asynchronous to mclk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module pel_sync
(
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic din,
   output logic      dout
);
   logic [1:0] sync_reg;   // Stage 0 then stage 1.

   // ==========================================================
   // Synchroniser
   // Both stages reset low; the pin must settle two edges.
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         sync_reg <= 2'b00;
      end
      else
      begin
         sync_reg <= {sync_reg[0], din};
      end
   end
   assign dout = sync_reg[1];
endmodule
`default_nettype wire

/* File: hw/pel_dead.sv */
// Purpose: Dead-time insertion for the primary and complementary outputs.
// Assumes: Raw waveform is high during the active (duty) part.
// Notes:   Both outputs stay off while the dead counter runs.
`timescale 1ns/1ps
`default_nettype none
`include "pel_params.svh"
module pel_dead
(
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       raw,
   input  wire logic [7:0] dead,
   output logic            prim_act,
   output logic            comp_act
);
   typedef struct packed
   {
      logic       last;
      logic [7:0] cnt;
      logic       prim;
      logic       comp;
   } pel_dead_s;
   pel_dead_s st_reg;   // Registered state.
   pel_dead_s st_next;  // Next state.

   // ==========================================================
   // Next state
   // Any edge of the raw waveform reloads the gap; the new side turns on
   // only once the gap has fully elapsed, so the two never overlap.
   always_comb
   begin
      st_next = st_reg;
      st_next.last = raw;
      if (raw != st_reg.last)
      begin
         st_next.cnt  = dead;
         st_next.prim = 1'b0;
         st_next.comp = 1'b0;
      end
      else if (st_reg.cnt > `PEL_DEAD_ONE)
      begin
         st_next.cnt = st_reg.cnt - `PEL_DEAD_ONE;
      end
      else
      begin
         st_next.cnt  = `PEL_DEAD_ZERO;
         st_next.prim = raw;
         st_next.comp = !raw;
      end
   end

   // Register the state.
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end
   assign prim_act = st_reg.prim;
   assign comp_act = st_reg.comp;
endmodule
`default_nettype wire

/* File: hw/pel_top.sv */
// Purpose: Enable, fault shutdown and write lock of a 12-bit PWM timer.
// Assumes: mclk at 20 MHz; one PWM count per prescaled clock tick.
// Notes:   Pins are driven only when the matching enable is set.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "pel_params.svh"
module pel_top
   import pel_pkg::*;
(
   input  wire logic           mclk,
   input  wire logic           rstn,
   input  wire pel_pkg::pel_bus_s bus,
   output logic [7:0]          rdata,
   input  wire logic           fault_pin,
   output pel_pkg::pel_pins_s  pins,
   output logic                irq
);
   import pel_pkg::*;

   typedef struct packed
   {
      logic [7:0] ovr;       // Output disable override register.
      logic [7:0] en;        // Module enable register.
      logic [7:0] ctrl;      // Control register (software copy).
      logic [7:0] ctrl_act;  // Control bits in use this period.
      pel_cnt_t   per;       // Period, software copy.
      pel_cnt_t   dut;       // Duty, software copy.
      pel_cnt_t   per_act;   // Period in use this period.
      pel_cnt_t   dut_act;   // Duty in use this period.
      logic [7:0] dead;      // Dead time in clocks.
      logic [7:0] lock;      // Write lock key.
      logic [1:0] stat;      // Sticky interrupt status.
      logic [1:0] mask;      // Interrupt mask.
      logic [3:0] pre;       // Prescaler.
      pel_cnt_t   cnt;       // Period counter.
      logic [7:0] rdata;     // Read data, one cycle after strobe.
   } pel_state_s;

   pel_state_s st_reg;       // Registered state.
   pel_state_s st_next;      // Next state.
   logic       fault_sync;   // Synchronised fault pin.
   logic       held_off;     // Outputs forced to the inactive level.
   logic       raw;          // Raw waveform, high in duty time.
   logic       prim_act;     // Primary active after dead time.
   logic       comp_act;     // Complementary active after dead time.
   logic       fault_now;    // Enabled fault level present.
   logic       tick;         // Prescaled PWM clock tick.
   logic       wrap;         // Last count of a period.
   logic       unlocked;     // Lock holds the key.
   logic       pol;          // Active level select in use.

   // Write strobe to one address.
   function automatic logic hit(input pel_bus_s b, input logic [7:0] a);
      hit = b.wr && (b.addr == a);
   endfunction

   // ==========================================================
   // Fault input
   pel_sync u_sync
   (
      .mclk (mclk),
      .rstn (rstn),
      .din  (fault_pin),
      .dout (fault_sync)
   );

   // Level select picks the polarity; the enable gates it entirely.
   assign fault_now = st_reg.en[`PEL_BIT_FAULT_EN] &&
                      (fault_sync == st_reg.ctrl[`PEL_BIT_FAULT_LVL]);
   // A latched fault status keeps the outputs inactive after the pin recovers,
   // until software clears it, so a chattering sensor cannot re-arm them.
   assign held_off  = fault_now || st_reg.ctrl[`PEL_BIT_FAULT_STAT];
   assign unlocked  = (st_reg.lock == `PEL_UNLOCK_KEY);
   assign pol       = st_reg.ctrl_act[`PEL_BIT_POL];

   // ==========================================================
   // Counter and waveform
   // Prescaler divides by 2, 4, 8 or 16 per the clock select field.
   always_comb
   begin
      unique case (st_reg.ctrl_act[1:0])
         2'b00:   tick = st_reg.pre[0];
         2'b01:   tick = &st_reg.pre[1:0];
         2'b10:   tick = &st_reg.pre[2:0];
         2'b11:   tick = &st_reg.pre[3:0];
      endcase
   end
   assign wrap = tick && (st_reg.cnt >= st_reg.per_act - `PEL_CNT_ONE);
   // Zero period holds the output inactive; duty >= period holds active.
   assign raw  = (st_reg.per_act != `PEL_CNT_ZERO) &&
                 (st_reg.cnt < st_reg.dut_act);

   pel_dead u_dead
   (
      .mclk     (mclk),
      .rstn     (rstn),
      .raw      (raw),
      .dead     (st_reg.dead),
      .prim_act (prim_act),
      .comp_act (comp_act)
   );

   // ==========================================================
   // Pin drive
   // Fault gating is combinational so the outputs drop at once.
   always_comb
   begin
      pins.prim_o  = (prim_act && !held_off) ^ pol;
      pins.comp_o  = (comp_act && !held_off) ^ pol;
      pins.prim_oe = st_reg.en[`PEL_BIT_PRIM_EN] && !st_reg.ovr[`PEL_BIT_OVR];
      pins.comp_oe = st_reg.en[`PEL_BIT_COMP_EN] && !st_reg.ovr[`PEL_BIT_OVR];
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      st_next = st_reg;
      st_next.pre = st_reg.pre + 4'h1;
      // The timer counts whenever the primary enable is set, even under override.
      if (st_reg.en[`PEL_BIT_PRIM_EN] && tick)
      begin
         st_next.cnt = wrap ? `PEL_CNT_ZERO : st_reg.cnt + `PEL_CNT_ONE;
      end
      // Shadow copies load at a period boundary, or at once while idle.
      if (wrap || !st_reg.en[`PEL_BIT_PRIM_EN])
      begin
         st_next.per_act  = st_reg.per;
         st_next.dut_act  = st_reg.dut;
         st_next.ctrl_act = st_reg.ctrl;
      end
      // Software writes; protected ones dropped without trace.
      if (unlocked)
      begin
         if (hit(bus, `PEL_OFS_EN))   st_next.en   = bus.wdata & `PEL_EN_MASK;
         if (hit(bus, `PEL_OFS_OVR))  st_next.ovr  = {7'h00, bus.wdata[`PEL_BIT_OVR]};
         if (hit(bus, `PEL_OFS_PERL)) st_next.per[7:0]  = bus.wdata;
         if (hit(bus, `PEL_OFS_PERH)) st_next.per[11:8] = bus.wdata[3:0];
         if (hit(bus, `PEL_OFS_DUTL)) st_next.dut[7:0]  = bus.wdata;
         if (hit(bus, `PEL_OFS_DUTH)) st_next.dut[11:8] = bus.wdata[3:0];
         if (hit(bus, `PEL_OFS_DEAD)) st_next.dead = bus.wdata;
         if (hit(bus, `PEL_OFS_CTRL))
         begin
            st_next.ctrl = (st_reg.ctrl & ~`PEL_CTRL_WMASK) | (bus.wdata & `PEL_CTRL_WMASK);
            // Flags only clear by writing zero; a held fault wins.
            if (!bus.wdata[`PEL_BIT_IF])   st_next.ctrl[`PEL_BIT_IF]   = 1'b0;
            if (!bus.wdata[`PEL_BIT_FAULT_STAT]) st_next.ctrl[`PEL_BIT_FAULT_STAT] = 1'b0;
         end
      end
      if (hit(bus, `PEL_OFS_LOCK))     st_next.lock = bus.wdata;
      if (hit(bus, `PEL_OFS_IRQ_MASK)) st_next.mask = bus.wdata[1:0];
      if (hit(bus, `PEL_OFS_IRQ_STAT)) st_next.stat = st_reg.stat & ~bus.wdata[1:0];
      // Hardware set wins over any clear in the same cycle.
      if (wrap && st_reg.en[`PEL_BIT_PRIM_EN])
      begin
         st_next.ctrl[`PEL_BIT_IF]        = 1'b1;
         st_next.stat[`PEL_IRQ_PERIOD]    = 1'b1;
      end
      if (fault_now)
      begin
         st_next.ctrl[`PEL_BIT_FAULT_STAT] = 1'b1;
         st_next.stat[`PEL_IRQ_FAULT]     = 1'b1;
      end
      // Read data for the cycle after the strobe.
      st_next.rdata = `PEL_BYTE_ZERO;
      if (bus.rd)
      begin
         unique case (bus.addr)
            `PEL_OFS_OVR:      st_next.rdata = st_reg.ovr;
            `PEL_OFS_EN:       st_next.rdata = st_reg.en;
            `PEL_OFS_CTRL:     st_next.rdata = st_reg.ctrl & `PEL_CTRL_RMASK;
            `PEL_OFS_PERL:     st_next.rdata = st_reg.per[7:0];
            `PEL_OFS_PERH:     st_next.rdata = {4'h0, st_reg.per[11:8]};
            `PEL_OFS_DUTL:     st_next.rdata = st_reg.dut[7:0];
            `PEL_OFS_DUTH:     st_next.rdata = {4'h0, st_reg.dut[11:8]};
            `PEL_OFS_DEAD:     st_next.rdata = st_reg.dead;
            `PEL_OFS_LOCK:     st_next.rdata = st_reg.lock;
            `PEL_OFS_IRQ_STAT: st_next.rdata = {6'h00, st_reg.stat};
            `PEL_OFS_IRQ_MASK: st_next.rdata = {6'h00, st_reg.mask};
            default:           st_next.rdata = `PEL_BYTE_ZERO;
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign rdata = st_reg.rdata;
   assign irq   = |(st_reg.stat & st_reg.mask);

   // ==========================================================
   // Assertions
   property p_locked_en;
      @(posedge mclk) disable iff (!rstn)
      (bus.wr && bus.addr == `PEL_OFS_EN && st_reg.lock != `PEL_UNLOCK_KEY)
         |=> $stable(st_reg.en);
   endproperty
   a_locked_en: assert property (p_locked_en) else $error("locked enable changed");

   property p_lock_write;
      @(posedge mclk) disable iff (!rstn)
      hit(bus, `PEL_OFS_LOCK) |=> st_reg.lock == $past(bus.wdata);
   endproperty
   a_lock_write: assert property (p_lock_write) else $error("lock not written");

   property p_fault_off;
      @(posedge mclk) disable iff (!rstn)
      fault_now |-> (pins.prim_o == pol) && (pins.comp_o == pol);
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("fault not inactive");

   property p_no_fault;
      @(posedge mclk) disable iff (!rstn)
      !st_reg.en[`PEL_BIT_FAULT_EN] |-> !fault_now;
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("fault while disabled");

   property p_fault_stat_set;
      @(posedge mclk) disable iff (!rstn)
      fault_now |=> st_reg.ctrl[`PEL_BIT_FAULT_STAT];
   endproperty
   a_fault_stat_set: assert property (p_fault_stat_set) else $error("fault status not set");

   property p_override;
      @(posedge mclk) disable iff (!rstn)
      st_reg.ovr[`PEL_BIT_OVR] |-> !pins.prim_oe && !pins.comp_oe;
   endproperty
   a_override: assert property (p_override) else $error("override ignored");

   property p_period_irq;
      @(posedge mclk) disable iff (!rstn)
      (wrap && st_reg.en[`PEL_BIT_PRIM_EN]) |=> st_reg.stat[`PEL_IRQ_PERIOD];
   endproperty
   a_period_irq: assert property (p_period_irq) else $error("period flag missing");

   property p_en_zero;
      @(posedge mclk) disable iff (!rstn)
      (st_reg.en == `PEL_BYTE_ZERO) |-> !pins.prim_oe && !pins.comp_oe;
   endproperty
   a_en_zero: assert property (p_en_zero) else $error("output with enable clear");

   property p_no_overlap;
      @(posedge mclk) disable iff (!rstn)
      !(prim_act && comp_act);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("outputs overlap");

   // Locked low-byte period writes must leave the software copy untouched as well.
   property p_locked_per;
      @(posedge mclk) disable iff (!rstn)
      (hit(bus, `PEL_OFS_PERL) && !unlocked) |=> $stable(st_reg.per);
   endproperty
   a_locked_per: assert property (p_locked_per) else $error("locked period changed");

   // Reset clears lock, enables and override whatever ran before it.
   property p_reset_zero;
      @(posedge mclk)
      !rstn |=> (st_reg.lock == `PEL_BYTE_ZERO) && (st_reg.en == `PEL_BYTE_ZERO) &&
                (st_reg.ovr == `PEL_BYTE_ZERO);
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

   // Inside a running period the values in use stay put; only a wrap reloads them,
   // so a half-written period or duty reaches the waveform only if a wrap falls between its byte writes.
   sequence s_mid_period;
      st_reg.en[`PEL_BIT_PRIM_EN] && !wrap;
   endsequence
   sequence s_shadow_held;
      $stable(st_reg.per_act) && $stable(st_reg.dut_act) && $stable(st_reg.ctrl_act);
   endsequence
   property p_shadow_hold;
      @(posedge mclk) disable iff (!rstn)
      s_mid_period |=> s_shadow_held;
   endproperty
   a_shadow_hold: assert property (p_shadow_hold) else $error("values in use changed");
endmodule
`default_nettype wire

/* File: bench/pel_fault_src.sv */
// Purpose: Model of the fault sensor that drives the block's fault pin.
// Assumes: The sensor has a push-pull output, so the pin never floats.
// Notes:   The bench picks which level means a fault.
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Fault sensor
module pel_fault_src
(
   input  wire logic fault_on,
   input  wire logic fault_high,
   output logic      fault_pin
);
   // The pin shows the fault level during a fault and the other level otherwise.
   assign fault_pin = fault_on ? fault_high : ~fault_high;
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: Self-checking bench for the PWM enable, fault and lock block.
// Assumes: Register port strobes are one cycle; read data follow one cycle later.
// Notes:   The waveform itself is not judged here, only enables, lock, override, period interrupt and fault.
`timescale 1ns/1ps
`default_nettype none
`include "pel_params.svh"
`define CHK(g, e) chk(8'(g), 8'(e))
// ============================================================
// Bench top
module tb;
   import pel_pkg::*;
   logic      mclk;
   logic      rstn;
   pel_bus_s  bus;
   logic [7:0] rdata;
   logic      fault_pin;
   pel_pins_s pins;
   logic      irq;
   logic      fault_on;
   logic      fault_high;
   int        fails = 0;
   int        n_compared = 0;

   pel_top dut (.mclk(mclk), .rstn(rstn), .bus(bus), .rdata(rdata),
                .fault_pin(fault_pin), .pins(pins), .irq(irq));
   pel_fault_src u_fault (.fault_on(fault_on), .fault_high(fault_high), .fault_pin(fault_pin));

   // The clock runs at 20 MHz.
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // ============================================================
   // Shared tasks
   task chk(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e)
      begin
         fails++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge mclk);
      bus.wr    <= 1'b0;
   endtask

   // Read data are taken only in the cycle after the taking edge.
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge mclk);
      bus.rd   <= 1'b0;
      #1 d = rdata;
   endtask

   task rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] r;
      rd(a, r);
      chk(r, e);
   endtask

   // Polls one register bit under a bound, so a dead timer cannot hang the run.
   task wait_bit(input logic [7:0] a, input int b, output logic [7:0] r);
      for (int i = 0; i < 60; i++)
      begin
         rd(a, r);
         if (r[b] === 1'b1) break;
      end
   endtask

   task test_done;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ============================================================
   // Scenarios
   task t_reset;
      #1;
      `CHK(pins.prim_oe, 1'b0);
      `CHK(pins.comp_oe, 1'b0);
      rchk(`PEL_OFS_LOCK, 8'h00);
      rchk(`PEL_OFS_EN, 8'h00);
      rchk(`PEL_OFS_OVR, 8'h00);
   endtask

   // Keys next to the unlock value must still block protected writes.
   task t_lock;
      logic [7:0] keys [4] = '{8'h00, 8'h54, 8'h56, 8'haa};
      foreach (keys[i])
      begin
         wr(`PEL_OFS_LOCK, keys[i]);
         wr(`PEL_OFS_EN, 8'hff);
         rchk(`PEL_OFS_LOCK, keys[i]);
         rchk(`PEL_OFS_EN, 8'h00);
      end
      wr(`PEL_OFS_LOCK, `PEL_UNLOCK_KEY);
      wr(`PEL_OFS_EN, 8'hff);
      #1 `CHK(pins.prim_oe, 1'b1);
      `CHK(pins.comp_oe, 1'b1);
      rchk(`PEL_OFS_EN, `PEL_EN_MASK);
      rchk(8'h00, 8'h00);
      wr(`PEL_OFS_EN, 8'h01);
      #1 `CHK(pins.comp_oe, 1'b0);
      `CHK(pins.prim_oe, 1'b1);
      wr(`PEL_OFS_EN, 8'h00);
      #1 `CHK(pins.prim_oe, 1'b0);
   endtask

   // Period event with mask, then override while the timer keeps counting.
   task t_period;
      logic [7:0] r;
      // The slowest prescale runs here; the fault passes use the fastest one.
      wr(`PEL_OFS_CTRL, 8'h03);
      wr(`PEL_OFS_PERL, 8'h04);
      wr(`PEL_OFS_DUTL, 8'h02);
      wr(`PEL_OFS_IRQ_MASK, 8'h00);
      wr(`PEL_OFS_IRQ_STAT, 8'hff);
      wr(`PEL_OFS_EN, 8'h09);
      wait_bit(`PEL_OFS_IRQ_STAT, `PEL_IRQ_PERIOD, r);
      `CHK(r[`PEL_IRQ_PERIOD], 1'b1);
      `CHK(irq, 1'b0);
      wr(`PEL_OFS_IRQ_MASK, 8'h01);
      #1 `CHK(irq, 1'b1);
      wr(`PEL_OFS_OVR, 8'h01);
      #1 `CHK(pins.prim_oe, 1'b0);
      `CHK(pins.comp_oe, 1'b0);
      wr(`PEL_OFS_IRQ_STAT, 8'h01);
      wait_bit(`PEL_OFS_IRQ_STAT, `PEL_IRQ_PERIOD, r);
      `CHK(r[`PEL_IRQ_PERIOD], 1'b1);
      rchk(`PEL_OFS_OVR, 8'h01);
      wr(`PEL_OFS_EN, 8'h00);
      wr(`PEL_OFS_IRQ_STAT, 8'hff);
      #1 `CHK(irq, 1'b0);
      wr(`PEL_OFS_OVR, 8'h00);
   endtask

   // One fault pass for a given inactive level p and fault level f.
   task t_fault(input logic p, input logic f);
      logic [7:0] c;
      logic [7:0] r;
      c = {4'h0, f, p, 2'b00};
      wr(`PEL_OFS_EN, 8'h00);
      wr(`PEL_OFS_CTRL, c);
      fault_high <= f;
      fault_on <= 1'b0;
      repeat (4) @(posedge mclk);
      wr(`PEL_OFS_EN, 8'h09);
      fault_on <= 1'b1;
      repeat (6) @(posedge mclk);
      rd(`PEL_OFS_CTRL, r);
      `CHK(r[`PEL_BIT_FAULT_STAT], 1'b0);
      wr(`PEL_OFS_EN, 8'h49);
      for (int i = 0; i < 8 && pins.prim_o !== p; i++) @(posedge mclk);
      #1 `CHK(pins.prim_o, p);
      `CHK(pins.comp_o, p);
      rd(`PEL_OFS_CTRL, r);
      `CHK(r[`PEL_BIT_FAULT_STAT], 1'b1);
      wr(`PEL_OFS_CTRL, c);
      rd(`PEL_OFS_CTRL, r);
      `CHK(r[`PEL_BIT_FAULT_STAT], 1'b1);
      `CHK(pins.prim_o, p);
      fault_on <= 1'b0;
      repeat (4) @(posedge mclk);
      wr(`PEL_OFS_EN, 8'h00);
      wr(`PEL_OFS_CTRL, c);
      rd(`PEL_OFS_CTRL, r);
      `CHK(r[`PEL_BIT_FAULT_STAT], 1'b0);
   endtask

   // A reset in mid-run must relock the registers and release the pins.
   task t_rerst;
      wr(`PEL_OFS_LOCK, `PEL_UNLOCK_KEY);
      wr(`PEL_OFS_EN, 8'h09);
      #1 `CHK(pins.prim_oe, 1'b1);
      wr(`PEL_OFS_OVR, 8'h01);
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      rchk(`PEL_OFS_LOCK, 8'h00);
      rchk(`PEL_OFS_EN, 8'h00);
      rchk(`PEL_OFS_OVR, 8'h00);
      wr(`PEL_OFS_PERL, 8'h0f);
      rchk(`PEL_OFS_PERL, 8'h00);
      #1 `CHK(pins.prim_oe, 1'b0);
   endtask

   // ============================================================
   // Main sequence
   initial
   begin
      rstn     = 1'b0;
      bus      = '0;
      fault_on = 1'b0;
      fault_high = 1'b0;
      repeat (16) @(posedge mclk);
      rstn <= 1'b1;
      t_reset;
      t_lock;
      t_period;
      for (int i = 0; i < 4; i++)
         t_fault(i[0], i[1]);
      t_rerst;
      test_done;
   end

   // The whole run needs well under 2000 cycles, so 4000 means a hang.
   initial
   begin
      repeat (4000) @(posedge mclk);
      fails++;
      test_done;
   end
endmodule
`default_nettype wire
